//--- logic/lcd_clk_pkg.sv
// shared constants for the lcd frame and boost clock select block
package lcd_clk_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  // control register field positions
  localparam int FBS_LSB = 0;
  localparam int DUTY_LSB = 2;
  localparam int BCS_LSB = 4;
  localparam int BOOST_EN_BIT = 6;
  localparam int DV7_SRC_BIT = 7;
  localparam int SYS_CLK_BIT = 8;
  localparam int CTRL_WIDTH = 9;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 9'h000;
  // status register field positions
  localparam int ST_USE_FS_BIT = 0;
  localparam int ST_FRAME_CLK_BIT = 1;
  localparam int ST_BOOST_CLK_BIT = 2;
  localparam int ST_BOOST_ON_BIT = 3;
  localparam int ST_DUTY_BAD_BIT = 4;
  localparam int ST_SLOW_BAD_BIT = 5;
  // divider chain lengths
  localparam int FC_STAGES = 17;
  localparam int FS_STAGES = 9;
  // drive duty codes
  typedef enum logic [1:0] {
    DUTY_QUARTER = 2'h0,
    DUTY_THIRD = 2'h1,
    DUTY_HALF = 2'h2,
    DUTY_STATIC = 2'h3
  } duty_t;
  // frame half period in eighth-base ticks for each duty, boost half period in boost tap ticks
  localparam logic [2:0] HALF_QUARTER = 3'h4;
  localparam logic [2:0] HALF_THIRD = 3'h3;
  localparam logic [2:0] HALF_HALF = 3'h2;
  localparam logic [2:0] HALF_STATIC = 3'h4;
  localparam logic [2:0] HALF_BOOST = 3'h1;
  // divider exponents of the taps feeding the frame shaper (base / 8)
  localparam int FR_TAP_FC0 = 14;
  localparam int FR_TAP_FC1 = 13;
  localparam int FR_TAP_FC2 = 12;
  localparam int FR_TAP_FC3 = 10;
  localparam int FR_TAP_FS0 = 6;
  localparam int FR_TAP_FS1 = 5;
  // divider exponents of the taps feeding the boost shaper (boost * 2)
  localparam int BO_TAP_FC0 = 12;
  localparam int BO_TAP_FC1 = 10;
  localparam int BO_TAP_FC2 = 9;
  localparam int BO_TAP_FC3 = 8;
  localparam int BO_TAP_FS0 = 4;
  localparam int BO_TAP_FS1 = 2;
  localparam int BO_TAP_FS2 = 1;
  // low-speed sources start at this tap index
  localparam logic [2:0] FS_TAP_BASE = 3'h4;
endpackage

//--- logic/clock_shaper.sv
// glitch-free square clock from a selectable tick tap
`timescale 1ns/100ps
module clock_shaper #(
  parameter int N = 6,
  parameter int SW = 3,
  parameter int CW = 3
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // selection
  input wire logic run_i,
  input wire logic [N-1:0] taps_i,
  input wire logic [SW-1:0] sel_i,
  input wire logic [CW-1:0] half_i,
  // derived clock
  output logic clk_o,
  output logic tick_o
);
  logic [SW-1:0] sel_reg;
  logic [CW-1:0] half_reg;
  logic [CW-1:0] cnt_reg;
  logic active_reg;
  logic clk_reg;
  logic tick_reg;

  wire tap = taps_i[sel_reg];
  wire last = (cnt_reg == (half_reg - 1'b1));
  wire step = active_reg & tap;
  wire wrap = step & last;
  // settings land at a falling edge or before the low phase has seen a tick:
  // a high phase is never cut short, and a disabled clock parks low at the next falling edge or unticked low phase
  wire low_start = ~clk_reg & (cnt_reg == '0) & ~step;
  wire boundary = ~active_reg | (wrap & clk_reg) | low_start;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sel_reg <= '0;
      half_reg <= '0;
      active_reg <= 1'b0;
    end else if (boundary) begin
      sel_reg <= sel_i;
      half_reg <= half_i;
      active_reg <= run_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || !active_reg) begin
      cnt_reg <= '0;
      clk_reg <= 1'b0;
    end else if (step) begin
      cnt_reg <= last ? '0 : cnt_reg + 1'b1;
      clk_reg <= wrap ? ~clk_reg : clk_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= wrap & ~clk_reg;
    end
  end

  assign clk_o = clk_reg;
  assign tick_o = tick_reg;
endmodule

//--- logic/lcd_clock_select.sv
// lcd frame and boost clock selection with avalon-mm control registers
`timescale 1ns/100ps
module lcd_clock_select
  import lcd_clk_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // source clock enables, one cycle each
  input wire logic fc_tick_i,
  input wire logic fs_tick_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // derived clocks
  output logic frame_clk_o,
  output logic frame_tick_o,
  output logic boost_clk_o,
  output logic boost_tick_o,
  // drive voltage source
  output logic booster_on_o,
  output logic resistor_divider_o
);
  import lcd_clk_pkg::*;

  logic [CTRL_WIDTH-1:0] ctrl_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic [FC_STAGES-1:0] fc_cnt_reg;
  logic [FS_STAGES-1:0] fs_cnt_reg;
  logic booster_reg;
  logic divider_reg;

  // ---- bus slave: one wait state, write lands on the acknowledge edge
  wire req = avs_read_i | avs_write_i;
  wire hit_ctrl = (avs_address_i == CTRL_OFFSET);
  wire hit_status = (avs_address_i == STATUS_OFFSET);
  wire wr_ctrl = avs_write_i & ack_reg & hit_ctrl;
  assign avs_waitrequest_o = req & ~ack_reg;
  assign avs_readdata_o = rdata_reg;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // byte lanes 0 and 1 carry the control fields
  wire [CTRL_WIDTH-1:0] ctrl_be = {avs_byteenable_i[1], {8{avs_byteenable_i[0]}}};
  wire [CTRL_WIDTH-1:0] ctrl_next =
    (ctrl_reg & ~ctrl_be) | (avs_writedata_i[CTRL_WIDTH-1:0] & ctrl_be);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ---- control fields
  wire [1:0] frame_base_select = ctrl_reg[FBS_LSB +: 2];
  wire [1:0] duty_select = ctrl_reg[DUTY_LSB +: 2];
  wire [1:0] boost_clock_select = ctrl_reg[BCS_LSB +: 2];
  wire boost_enable = ctrl_reg[BOOST_EN_BIT];
  wire divider_stage7_source = ctrl_reg[DV7_SRC_BIT];
  wire system_clock_select = ctrl_reg[SYS_CLK_BIT];
  wire use_fs = divider_stage7_source | system_clock_select;
  wire low_speed_modes = system_clock_select;

  // ---- dedicated divider chains, free of any other timer
  // private divider chain
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fc_cnt_reg <= '0;
    end else if (fc_tick_i) begin
      fc_cnt_reg <= fc_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fs_cnt_reg <= '0;
    end else if (fs_tick_i) begin
      fs_cnt_reg <= fs_cnt_reg + 1'b1;
    end
  end

  // fc_tap[k] pulses once every 2^k source ticks
  logic [FC_STAGES:1] fc_tap;
  logic [FS_STAGES:1] fs_tap;
  genvar k;
  generate
    for (k = 1; k <= FC_STAGES; k++) begin : g_fc
      assign fc_tap[k] = fc_tick_i & (&fc_cnt_reg[k-1:0]);
    end
    for (k = 1; k <= FS_STAGES; k++) begin : g_fs
      assign fs_tap[k] = fs_tick_i & (&fs_cnt_reg[k-1:0]);
    end
  endgenerate

  // ---- frame clock: taps run at eight times the base rate
  wire [5:0] frame_taps = {fs_tap[FR_TAP_FS1], fs_tap[FR_TAP_FS0],
                           fc_tap[FR_TAP_FC3], fc_tap[FR_TAP_FC2],
                           fc_tap[FR_TAP_FC1], fc_tap[FR_TAP_FC0]};
  wire [2:0] frame_fc_sel = {1'b0, frame_base_select};
  // slow base for codes 00 and 01; 10 and 11 stay on fc as in dual mode
  wire frame_on_fs = use_fs & ~frame_base_select[1];
  wire [2:0] frame_sel = frame_on_fs ? (FS_TAP_BASE | frame_fc_sel) : frame_fc_sel;

  // duty scales the frame rate via the half period
  wire [2:0] frame_half = (duty_select == DUTY_QUARTER) ? HALF_QUARTER :
                          (duty_select == DUTY_THIRD) ? HALF_THIRD :
                          (duty_select == DUTY_HALF) ? HALF_HALF : HALF_STATIC;

  clock_shaper #(
    .N(6),
    .SW(3),
    .CW(3)
  ) u_frame (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .run_i(1'b1),
    .taps_i(frame_taps),
    .sel_i(frame_sel),
    .half_i(frame_half),
    .clk_o(frame_clk_o),
    .tick_o(frame_tick_o)
  );

  // ---- boost clock: taps run at twice the boost rate
  wire [6:0] boost_taps = {fs_tap[BO_TAP_FS2], fs_tap[BO_TAP_FS1], fs_tap[BO_TAP_FS0],
                           fc_tap[BO_TAP_FC3], fc_tap[BO_TAP_FC2],
                           fc_tap[BO_TAP_FC1], fc_tap[BO_TAP_FC0]};
  wire [2:0] boost_fc_sel = {1'b0, boost_clock_select};
  wire boost_on_fs = use_fs & ~(&boost_clock_select);
  wire [2:0] boost_sel = boost_on_fs ? (FS_TAP_BASE | boost_fc_sel) : boost_fc_sel;

  // the booster clock runs while the booster is selected, then parks low at its next falling edge or unticked low phase
  clock_shaper #(
    .N(7),
    .SW(3),
    .CW(3)
  ) u_boost (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .run_i(boost_enable),
    .taps_i(boost_taps),
    .sel_i(boost_sel),
    .half_i(HALF_BOOST),
    .clk_o(boost_clk_o),
    .tick_o(boost_tick_o)
  );

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      booster_reg <= 1'b0;
      divider_reg <= 1'b1;
    end else begin
      booster_reg <= boost_enable;
      divider_reg <= ~boost_enable;
    end
  end
  assign booster_on_o = booster_reg;
  assign resistor_divider_o = divider_reg;

  // ---- status: misuse is only reported, the hardware does not block it
  // duty misuse flag
  wire duty_bad = boost_enable & duty_select[1];
  wire slow_frame_bad = low_speed_modes & frame_base_select[1];
  wire slow_boost_bad = low_speed_modes & (&boost_clock_select);

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_USE_FS_BIT] = use_fs;
    status_word[ST_FRAME_CLK_BIT] = frame_clk_o;
    status_word[ST_BOOST_CLK_BIT] = boost_clk_o;
    status_word[ST_BOOST_ON_BIT] = booster_reg;
    status_word[ST_DUTY_BAD_BIT] = duty_bad;
    status_word[ST_SLOW_BAD_BIT] = slow_frame_bad | slow_boost_bad;
  end

  wire [31:0] ctrl_word = {{(32-CTRL_WIDTH){1'b0}}, ctrl_reg};
  wire [31:0] read_mux = hit_ctrl ? ctrl_word : (hit_status ? status_word : 32'h0000_0000);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_reg) begin
      rdata_reg <= read_mux;
    end
  end
endmodule

//--- tb/lcd_clock_select_monitor.sv
// port checker for the lcd clock select block
`timescale 1ns/100ps
module lcd_clock_select_monitor (
  // clock, reset and bus
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // derived clocks and drive source
  input wire logic frame_clk_o,
  input wire logic frame_tick_o,
  input wire logic boost_clk_o,
  input wire logic boost_tick_o,
  input wire logic booster_on_o,
  input wire logic resistor_divider_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  wire req = avs_read_i | avs_write_i;
  wire done = req & ~avs_waitrequest_o;
  wire ctrl_wr = done & avs_write_i & (avs_address_i == 4'h0) & avs_byteenable_i[0];
  wire odd_rd = done & avs_read_i & (avs_address_i != 4'h0) & (avs_address_i != 4'h4);
  wire en_bit = avs_writedata_i[6];
  // the boost clock may finish its period after disable, then it must stay low
  logic parked_reg;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      parked_reg <= 1'b1;
    end else if (booster_on_o) begin
      parked_reg <= 1'b0;
    end else if ($fell(boost_clk_o)) begin
      parked_reg <= 1'b1;
    end
  end
  a_one_wait: assert property (req & avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("wait too long");
  a_idle_ready: assert property (!req |-> !avs_waitrequest_o)
    else $error("wait without request");
  a_boost_copy: assert property (ctrl_wr |-> ##2 booster_on_o == $past(en_bit, 2))
    else $error("booster not following enable");
  a_divider_inverse: assert property (resistor_divider_o != booster_on_o)
    else $error("divider not inverse of booster");
  a_boost_gated: assert property (parked_reg |-> !boost_clk_o)
    else $error("boost clock while disabled");
  a_frame_tick: assert property ($rose(frame_clk_o) |-> frame_tick_o ##1 !frame_tick_o)
    else $error("frame tick missing");
  a_boost_tick: assert property ($rose(boost_clk_o) |-> boost_tick_o ##1 !boost_tick_o)
    else $error("boost tick missing");
  a_frame_no_runt: assert property ($rose(frame_clk_o) |-> frame_clk_o [*8])
    else $error("runt frame pulse");
  a_boost_no_runt: assert property ($fell(boost_clk_o) |-> !boost_clk_o [*2])
    else $error("runt boost gap");
  a_odd_zero: assert property (odd_rd |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind lcd_clock_select lcd_clock_select_monitor mon (.*);

//--- tb/lcd_panel_model.sv
// panel-side model timing the frame and booster clocks it receives
`timescale 1ns/100ps
module lcd_panel_model (
  // clocks seen by the panel
  input wire logic mclk_i,
  input wire logic frame_clk_i,
  input wire logic boost_clk_i,
  // measured periods and frame high time in system cycles, and rise counts
  output logic [31:0] frame_period_o = 32'h0,
  output logic [31:0] frame_high_o = 32'h0,
  output logic [31:0] boost_period_o = 32'h0,
  output logic [31:0] frame_rises_o = 32'h0,
  output logic [31:0] boost_rises_o = 32'h0
);
  logic [31:0] fcnt = 32'h0;
  logic [31:0] bcnt = 32'h0;
  logic fprev = 1'b0;
  logic bprev = 1'b0;
  always @(posedge mclk_i) begin
    fprev <= frame_clk_i;
    bprev <= boost_clk_i;
    fcnt <= (frame_clk_i & ~fprev) ? 32'h1 : fcnt + 32'h1;
    bcnt <= (boost_clk_i & ~bprev) ? 32'h1 : bcnt + 32'h1;
    if (frame_clk_i & ~fprev) begin
      frame_period_o <= fcnt;
      frame_rises_o <= frame_rises_o + 32'h1;
    end
    if (~frame_clk_i & fprev) frame_high_o <= fcnt;
    if (boost_clk_i & ~bprev) begin
      boost_period_o <= bcnt;
      boost_rises_o <= boost_rises_o + 32'h1;
    end
  end
endmodule

//--- tb/test_lcd_clock_select.sv
// self-checking bench for the lcd clock select block
`timescale 1ns/100ps
module test_lcd_clock_select;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic fc_tick_i = 1'b1;
  logic fs_tick_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o, fper, fhigh, bper, frises, brises, rdata;
  logic avs_waitrequest_o, frame_clk_o, frame_tick_o, boost_clk_o, boost_tick_o;
  logic booster_on_o, resistor_divider_o;
  // fc ticks every cycle, fs every other one, so periods below are in cycles
  // duty 1x only unboosted, no slow fast-only codes
  logic [8:0] cfg [8] = '{9'h043, 9'h0F1, 9'h080, 9'h155, 9'h165, 9'h0C1, 9'h189, 9'h10D};
  logic [31:0] fexp [8] = '{32'h2000, 32'h200, 32'h400, 32'h180,
    32'h180, 32'h200, 32'h100, 32'h200};
  logic [31:0] bexp [8] = '{32'h2000, 32'h200, 32'h0, 32'h10, 32'h8, 32'h40, 32'h0, 32'h0};
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  lcd_clock_select uut (.*);
  lcd_panel_model panel (.mclk_i(mclk_i), .frame_clk_i(frame_clk_o), .boost_clk_i(boost_clk_o),
    .frame_period_o(fper), .frame_high_o(fhigh), .boost_period_o(bper),
    .frame_rises_o(frises), .boost_rises_o(brises));
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) fs_tick_i <= ~fs_tick_i;
  task automatic stop_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge mclk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge mclk_i);
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rdata, e);
  endtask
  task automatic wait_rises();
    logic [31:0] f0;
    logic [31:0] b0;
    f0 = frises;
    b0 = brises;
    while (frises - f0 < 3 || (booster_on_o && brises - b0 < 3)) @(posedge mclk_i);
  endtask
  // the slowest scenario needs about three 2^13 periods; all together stay near 35k
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    check(32'(resistor_divider_o), 32'h1);
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    bus(1'b1, 4'h8, 32'h1FF);
    rd(4'h8, 32'h0);
    bus(1'b1, 4'h4, 32'h1FF);
    rd(4'h0, 32'h0);
    avs_byteenable_i <= 4'h2;
    bus(1'b1, 4'h0, 32'h1FF);
    avs_byteenable_i <= 4'hF;
    rd(4'h0, 32'h100);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 4'h0, {23'h0, cfg[i]});
      rd(4'h0, {23'h0, cfg[i]});
      wait_rises();
      check(fper, fexp[i]);
      check({fhigh[30:0], 1'b0}, fexp[i]);
      check(32'(booster_on_o), 32'(cfg[i][6]));
      check(32'(resistor_divider_o), 32'(!cfg[i][6]));
      check(booster_on_o ? bper : 32'(boost_clk_o), bexp[i]);
    end
    stop_test();
  end
endmodule
